/* flash_array.sv */
// byte array behind the flash command port, one synchronous port
// read data come out of a register; bulk erase sweeps one byte per clock
`timescale 1ns/1ns
module flash_array
    import flash_port_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // access
    input  wire logic [16:0] addr_i,
    input  wire logic        write_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o
);
`include "flash_port_regs.svh"

    logic [7:0] mem [0:131071];

    always_ff @(posedge clk_i)
    begin
        if (write_i)
        begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        rdata_o <= mem[addr_i];
    end

endmodule

/* flash_command_port.sv */
// command decoder, timers and data bus drive of the parallel flash port
// assumes strobes synchronous to clk_i; programmer keeps cycle timing
`timescale 1ns/1ns
`include "flash_port_regs.svh"
module flash_command_port
    import flash_port_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLES = `PROGRAM_CYCLES,
    parameter int unsigned ERASE_CYCLES   = `ERASE_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // supply level select
    input  wire logic        program_supply_high_i,
    // address: port 0, port 1, address_bit_16
    input  wire logic [16:0] addr_i,
    // data bus
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    // strobes
    input  wire logic        chip_en_n_i,
    input  wire logic        out_en_n_i,
    input  wire logic        write_n_i,
    // status
    output logic             busy_o
);

    port_state_type state;
    busy_op_type    op;
    logic [7:0]     cmd_latch;
    logic [16:0]    wr_addr;
    logic [16:0]    prog_addr;
    logic [16:0]    verify_addr;
    logic [7:0]     prog_data;
    logic [23:0]    timer;
    logic           write_n_q;
    logic           read_q;
    logic [16:0]    arr_addr;
    logic           arr_write;
    logic [7:0]     arr_wdata;
    logic [7:0]     arr_rdata;
    logic [16:0]    erase_ptr;
    logic           erase_sweep;

    function automatic logic known_code(input logic [7:0] code);
        known_code = (code == `CMD_READ) || (code == `CMD_PROGRAM)
            || (code == `CMD_PROG_VERIFY) || (code == `CMD_ERASE)
            || (code == `CMD_ERASE_VERIFY) || (code == `CMD_IDENT);
    endfunction

    wire write_mode = program_supply_high_i;
    wire wr_sel     = !chip_en_n_i && out_en_n_i;
    wire wr_fall    = wr_sel && write_n_q && !write_n_i;
    wire wr_rise    = wr_sel && !write_n_q && write_n_i;
    wire rd_cycle   = !chip_en_n_i && !out_en_n_i && write_n_i;
    wire cmd_ok     = write_mode && (state != st_busy);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            write_n_q <= 1'b1;
        else
            write_n_q <= write_n_i;
    end

    // address latch on the falling strobe edge
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            wr_addr <= 17'h00000;
        else if (wr_fall && cmd_ok)
            wr_addr <= addr_i;
    end

    // command sequencer
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state       <= st_idle;
            op          <= op_none;
            cmd_latch   <= `CMD_READ;
            prog_addr   <= 17'h00000;
            verify_addr <= 17'h00000;
            prog_data   <= 8'h00;
            timer       <= 24'h000000;
        end
        else if (state == st_busy)
        begin
            // commands ignored until the timer expires and any erase sweep has ended
            if (timer <= 24'h000001 && !erase_sweep)
            begin
                state     <= st_idle;
                op        <= op_none;
                cmd_latch <= `CMD_READ;
            end
            if (timer != 24'h000000)
                timer <= timer - 24'h000001;
        end
        else if (wr_rise && cmd_ok)
        begin
            case (state)
                st_idle:
                begin
                    if (data_i == `CMD_PROGRAM)
                        state <= st_prog_2;
                    else if (data_i == `CMD_ERASE)
                        state <= st_erase_2;
                    if (data_i == `CMD_ERASE_VERIFY)
                        verify_addr <= wr_addr;
                    if (known_code(data_i))
                        cmd_latch <= data_i;
                end
                st_prog_2:
                begin
                    if (data_i == `CMD_RESET)
                        state <= st_reset_3;
                    else
                    begin
                        prog_addr <= wr_addr;
                        prog_data <= data_i;
                        timer     <= 24'(PROGRAM_CYCLES);
                        op        <= op_prog;
                        state     <= st_busy;
                    end
                end
                st_erase_2:
                begin
                    if (data_i == `CMD_ERASE)
                    begin
                        timer <= 24'(ERASE_CYCLES);
                        op    <= op_erase;
                        state <= st_busy;
                    end
                    else if (data_i == `CMD_RESET)
                        state <= st_reset_3;
                    else
                    begin
                        state     <= st_idle;
                        cmd_latch <= `CMD_READ;
                    end
                end
                st_reset_3:
                begin
                    // second reset code or anything else: back to read
                    state     <= st_idle;
                    cmd_latch <= `CMD_READ;
                end
                default:
                    state <= st_idle;
            endcase
        end
        else if (!write_mode && state != st_idle)
        begin
            state     <= st_idle;
            cmd_latch <= `CMD_READ;
        end
    end

    // erase sweep runs inside the busy time, which waits for it; array ends all erased
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            erase_sweep <= 1'b0;
            erase_ptr   <= 17'h00000;
        end
        else if (wr_rise && cmd_ok && state == st_erase_2
                 && data_i == `CMD_ERASE)
        begin
            erase_sweep <= 1'b1;
            erase_ptr   <= 17'h00000;
        end
        else if (erase_sweep)
        begin
            erase_ptr <= erase_ptr + 17'h00001;
            if (erase_ptr == 17'h1ffff)
                erase_sweep <= 1'b0;
        end
    end

    // program writes once at the start of its timed window
    wire prog_start = (state == st_busy) && (op == op_prog)
                      && (timer == 24'(PROGRAM_CYCLES));

    always_comb
    begin
        arr_write = 1'b0;
        arr_wdata = prog_data;
        arr_addr  = addr_i;
        if (erase_sweep)
        begin
            arr_write = 1'b1;
            arr_wdata = `ERASED_BYTE;
            arr_addr  = erase_ptr;
        end
        else if (prog_start)
        begin
            arr_write = 1'b1;
            arr_addr  = prog_addr;
        end
        else if (write_mode && cmd_latch == `CMD_PROG_VERIFY)
            arr_addr = prog_addr;
        else if (write_mode && cmd_latch == `CMD_ERASE_VERIFY)
            arr_addr = verify_addr;
    end

    flash_array u_array
    (
        .clk_i   (clk_i),
        .addr_i  (arr_addr),
        .write_i (arr_write),
        .wdata_i (arr_wdata),
        .rdata_o (arr_rdata)
    );

    // output data register; ident bytes come one clock after the address, array bytes two
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            data_o <= 8'h00;
            read_q <= 1'b0;
        end
        else
        begin
            read_q <= rd_cycle && (state != st_busy);
            if (write_mode && cmd_latch == `CMD_IDENT)
            begin
                if (addr_i == `IDENT_ADDR_MAKER)
                    data_o <= `IDENT_VALUE_MAKER;
                else if (addr_i == `IDENT_ADDR_DEVICE)
                    data_o <= `IDENT_VALUE_DEVICE;
                else
                    data_o <= 8'h00;
            end
            else
                data_o <= arr_rdata;
        end
    end

    // bus floats in standby
    assign data_oe_o = read_q && rd_cycle;
    assign busy_o    = (state == st_busy);

endmodule

/* flash_port_pkg.sv */
// types for the parallel flash command port
// assumes nothing of its surroundings
package flash_port_pkg;

    typedef enum logic [4:0]
    {
        st_idle    = 5'b00001,
        st_prog_2  = 5'b00010,
        st_erase_2 = 5'b00100,
        st_reset_3 = 5'b01000,
        st_busy    = 5'b10000
    } port_state_type;

    typedef enum logic [1:0]
    {
        op_none  = 2'h0,
        op_prog  = 2'h1,
        op_erase = 2'h2
    } busy_op_type;

endpackage

/* flash_port_properties.sv */
// pin-level assertions for the flash command port
// assumes a bind onto flash_command_port, one clock domain
`timescale 1ns/1ns
module flash_port_properties #(
    parameter int unsigned PROGRAM_CYCLES = 250,
    parameter int unsigned ERASE_CYCLES   = 237500
)
(
    // watched pins
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic program_supply_high_i,
    input  wire logic data_oe_o,
    input  wire logic chip_en_n_i,
    input  wire logic out_en_n_i,
    input  wire logic write_n_i,
    input  wire logic busy_o
);
    int busy_len;

    // counts sampled busy cycles so the timer length can be judged
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            busy_len <= 0;
        else
            busy_len <= busy_o ? busy_len + 1 : 0;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_rd;
        !chip_en_n_i && !out_en_n_i && write_n_i;
    endsequence
    sequence s_rd_held;
        s_rd [*3];
    endsequence

    property p_standby; chip_en_n_i |-> !data_oe_o; endproperty
    property p_drive_only_read; data_oe_o |-> s_rd; endproperty
    property p_read_drives; s_rd_held |-> data_oe_o; endproperty
    property p_low_supply;
        !program_supply_high_i && !busy_o |=> !busy_o;
    endproperty
    property p_busy_cause;
        $rose(busy_o) |-> program_supply_high_i && write_n_i;
    endproperty
    property p_busy_min;
        $fell(busy_o) |-> busy_len >= PROGRAM_CYCLES - 1;
    endproperty
    property p_busy_max; busy_o |-> busy_len < ERASE_CYCLES + 131074;
    endproperty
    property p_reset_idle;
        $rose(reset_n_i) |-> !busy_o && !data_oe_o;
    endproperty

    a_standby: assert property (p_standby)
        else $error("bus driven in standby");
    a_drive_only_read: assert property (p_drive_only_read)
        else $error("bus driven outside a read cycle");
    a_read_drives: assert property (p_read_drives)
        else $error("read cycle without bus drive");
    a_low_supply: assert property (p_low_supply)
        else $error("operation started with low supply");
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without a strobe rise");
    a_busy_min: assert property (p_busy_min)
        else $error("timed operation ended early");
    a_busy_max: assert property (p_busy_max)
        else $error("timed operation never ended");
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
endmodule

bind flash_command_port flash_port_properties #(
    .PROGRAM_CYCLES(PROGRAM_CYCLES),
    .ERASE_CYCLES  (ERASE_CYCLES)
) u_flash_port_properties (
    .clk_i,
    .reset_n_i,
    .program_supply_high_i,
    .data_oe_o,
    .chip_en_n_i,
    .out_en_n_i,
    .write_n_i,
    .busy_o
);

/* flash_port_regs.svh */
// constants for the parallel flash command port
// assumes a 25 MHz system clock
`ifndef FLASH_PORT_REGS_SVH
`define FLASH_PORT_REGS_SVH

`define CMD_READ          8'h00
`define CMD_PROGRAM       8'h40
`define CMD_PROG_VERIFY   8'hc0
`define CMD_ERASE         8'h20
`define CMD_ERASE_VERIFY  8'ha0
`define CMD_RESET         8'hff
`define CMD_IDENT         8'h90

`define IDENT_ADDR_MAKER  17'h00000
`define IDENT_ADDR_DEVICE 17'h00001
// identification values are arbitrary
`define IDENT_VALUE_MAKER  8'h5a
`define IDENT_VALUE_DEVICE 8'ha5

`define ERASED_BYTE       8'hff
`define CLK_MHZ           25
`define PROGRAM_TIME_NS   10000
`define ERASE_TIME_NS     9500000
`define PROGRAM_CYCLES    ((`PROGRAM_TIME_NS * `CLK_MHZ) / 1000)
`define ERASE_CYCLES      ((`ERASE_TIME_NS * `CLK_MHZ) / 1000)

`endif

/* flash_programmer.sv */
// external programmer model for the flash command port pins
// assumes the bench calls one task at a time
`timescale 1ns/1ns
module flash_programmer
(
    // clock and device side
    input  wire logic        clk_i,
    input  wire logic [7:0]  dev_data_i,
    input  wire logic        dev_oe_i,
    // pins toward the device
    output logic      [16:0] addr_o,
    output logic      [7:0]  data_o,
    output logic             chip_en_n_o,
    output logic             out_en_n_o,
    output logic             write_n_o
);
    logic       drive = 1'b0;
    logic [7:0] wdata = 8'h00;

    // released bus shows the device byte while it drives, else the inverse of the last byte, never a stale copy
    assign data_o = drive ? wdata : (dev_oe_i ? dev_data_i : ~wdata);

    initial
    begin
        addr_o = 17'h00000;
        chip_en_n_o = 1'b1;
        out_en_n_o = 1'b1;
        write_n_o = 1'b1;
    end

    // one write cycle: address set with the fall, data held over the rise
    task automatic wr(input logic [16:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        wdata = v;
        drive = 1'b1;
        chip_en_n_o = 1'b0;
        write_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        write_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        chip_en_n_o = 1'b1;
        drive = 1'b0;
    endtask

    task automatic rd(input logic [16:0] a, output logic [7:0] v,
                      output logic on);
        @(negedge clk_i);
        addr_o = a;
        chip_en_n_o = 1'b0;
        out_en_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        v = dev_data_i;
        on = dev_oe_i;
        chip_en_n_o = 1'b1;
        out_en_n_o = 1'b1;
    endtask

    task automatic standby(output logic on);
        @(negedge clk_i);
        out_en_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        on = dev_oe_i;
        out_en_n_o = 1'b1;
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the flash command port
// assumes the programmer model makes every pin cycle
`timescale 1ns/1ns
`include "flash_port_regs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    localparam int unsigned PROG = 20;
    localparam logic [16:0] A = 17'h12345;
    localparam logic [16:0] B = 17'h00abc;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        supply_high = 1'b1;
    logic [16:0] addr;
    logic [7:0]  bus;
    logic [7:0]  rdata;
    logic        drv;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        busy;
    logic [7:0]  d;
    logic        on;
    int          n;
    int          err_total = 0;
    int          comparisons = 0;

    flash_command_port #(
        .PROGRAM_CYCLES(PROG),
        .ERASE_CYCLES  (100)
    ) u_flash_command_port (
        .clk_i                (clk),
        .reset_n_i            (reset_n),
        .program_supply_high_i(supply_high),
        .addr_i               (addr),
        .data_i               (bus),
        .data_o               (rdata),
        .data_oe_o            (drv),
        .chip_en_n_i          (ce_n),
        .out_en_n_i           (oe_n),
        .write_n_i            (we_n),
        .busy_o               (busy)
    );
    flash_programmer u_flash_programmer (
        .clk_i      (clk),
        .dev_data_i (rdata),
        .dev_oe_i   (drv),
        .addr_o     (addr),
        .data_o     (bus),
        .chip_en_n_o(ce_n),
        .out_en_n_o (oe_n),
        .write_n_o  (we_n)
    );

    initial
        forever #20 clk = ~clk;

    task automatic stop_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic w(input logic [16:0] a, input logic [7:0] v);
        u_flash_programmer.wr(a, v);
    endtask

    task automatic rc(input logic [16:0] a, input logic [7:0] e);
        u_flash_programmer.rd(a, d, on);
        `CHK("rdata", e, d)
        `CHK("drive", 1'b1, on)
    endtask

    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("prog_time", 1'b1, n <= PROG)
    endtask

    task automatic pulse_reset();
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
    endtask

    task automatic t_program();
        w(A, `CMD_PROGRAM);
        w(A, 8'h3c);
        `CHK("busy", 1'b1, busy)
        w(B, `CMD_PROGRAM);
        w(B, 8'hc3);
        wait_idle();
        w(B, `CMD_PROG_VERIFY);
        rc(B, 8'h3c);
    endtask

    task automatic t_read();
        w(B, `CMD_PROGRAM);
        w(B, 8'ha7);
        wait_idle();
        w(B, `CMD_READ);
        rc(A, 8'h3c);
        rc(B, 8'ha7);
    endtask

    task automatic t_ident();
        w(A, `CMD_IDENT);
        rc(`IDENT_ADDR_MAKER, `IDENT_VALUE_MAKER);
        rc(`IDENT_ADDR_DEVICE, `IDENT_VALUE_DEVICE);
        w(A, 8'h33);
        rc(`IDENT_ADDR_MAKER, `IDENT_VALUE_MAKER);
        w(A, `CMD_ERASE_VERIFY);
        rc(B, 8'h3c);
    endtask

    task automatic t_abort_low();
        w(A, `CMD_PROGRAM);
        w(A, `CMD_RESET);
        w(A, `CMD_RESET);
        `CHK("busy", 1'b0, busy)
        rc(A, 8'h3c);
        supply_high = 1'b0;
        w(A, `CMD_PROGRAM);
        w(A, 8'h55);
        `CHK("busy", 1'b0, busy)
        rc(A, 8'h3c);
        supply_high = 1'b1;
    endtask

    task automatic t_standby_power();
        u_flash_programmer.standby(on);
        `CHK("standby", 1'b0, on)
        w(A, `CMD_IDENT);
        pulse_reset();
        rc(A, 8'h3c);
    endtask

    task automatic t_erase();
        w(17'h00000, `CMD_PROGRAM);
        w(17'h00000, 8'h00);
        wait_idle();
        w(17'h00000, `CMD_PROG_VERIFY);
        rc(B, 8'h00);
        w(A, `CMD_ERASE);
        w(A, `CMD_RESET);
        w(A, `CMD_RESET);
        `CHK("busy", 1'b0, busy)
        w(A, `CMD_ERASE);
        w(A, 8'h55);
        `CHK("busy", 1'b0, busy)
        w(A, `CMD_ERASE);
        w(A, `CMD_ERASE);
        `CHK("busy", 1'b1, busy)
        // whole sweep outlasts the run: reset cuts it once address 0 is done
        pulse_reset();
        w(17'h00000, `CMD_ERASE_VERIFY);
        rc(B, `ERASED_BYTE);
        w(A, `CMD_ERASE);
        w(A, `CMD_ERASE);
        `CHK("busy", 1'b1, busy)
        pulse_reset();
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        t_program();
        t_read();
        t_ident();
        t_abort_low();
        t_standby_power();
        t_erase();
        stop_test();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
